/* msr_pkg.sv */
`default_nettype none
package msr_pkg;
    localparam int DATA_W = 32;
    localparam int MEM_AW = 9;
    localparam logic [9:0] MEM_DEPTH = 10'h200;

    localparam logic [7:0] ADDR_CMD   = 8'h00;
    localparam logic [7:0] ADDR_CFG   = 8'h04;
    localparam logic [7:0] ADDR_TCNT  = 8'h08;
    localparam logic [7:0] ADDR_TDLY  = 8'h0C;
    localparam logic [7:0] ADDR_LIMLO = 8'h10;
    localparam logic [7:0] ADDR_LIMHI = 8'h14;
    localparam logic [7:0] ADDR_QCOND = 8'h18;
    localparam logic [7:0] ADDR_QENA  = 8'h1C;
    localparam logic [7:0] ADDR_ESR   = 8'h20;
    localparam logic [7:0] ADDR_ESE   = 8'h24;
    localparam logic [7:0] ADDR_SRE   = 8'h28;
    localparam logic [7:0] ADDR_STB   = 8'h2C;
    localparam logic [7:0] ADDR_OBUF  = 8'h30;
    localparam logic [7:0] ADDR_OCNT  = 8'h34;
    localparam logic [7:0] ADDR_AVG   = 8'h38;
    localparam logic [7:0] ADDR_MIN   = 8'h3C;
    localparam logic [7:0] ADDR_MAX   = 8'h40;
    localparam logic [7:0] ADDR_SEQ   = 8'h44;

    localparam int CMD_INIT  = 0;
    localparam int CMD_FETCH = 1;
    localparam int CMD_READ  = 2;
    localparam int CMD_OPC   = 3;
    localparam int CMD_CLS   = 4;

    localparam int STB_QUES_BIT = 3;
    localparam int STB_MAV_BIT  = 4;
    localparam int STB_ESB_BIT  = 5;
    localparam int STB_RQS_BIT  = 6;
    localparam int ESR_OPC_BIT  = 0;
    localparam int QUES_LO_BIT  = 11;
    localparam int QUES_HI_BIT  = 12;

    localparam logic [1:0] MATH_NONE = 2'h0;
    localparam logic [1:0] MATH_AVG  = 2'h1;
    localparam logic [1:0] MATH_LIM  = 2'h2;

    localparam logic [15:0] TCNT_RST = 16'h0001;
    localparam logic [31:0] TDLY_RST = 32'h0000_0000;
    localparam logic signed [31:0] MIN_INIT = 32'sh7FFF_FFFF;
    localparam logic signed [31:0] MAX_INIT = 32'sh8000_0000;

    // Trigger delay counts in microsecond ticks
    localparam int CLK_PERIOD_PS = 5000;
    localparam int DELAY_UNIT_NS = 1000;
    localparam int TICK_CYCLES   = (DELAY_UNIT_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

    typedef enum logic [3:0] {
        SEQ_IDLE  = 4'b0001,
        SEQ_WTRIG = 4'b0010,
        SEQ_DELAY = 4'b0100,
        SEQ_MEAS  = 4'b1000
    } msr_seq_t;

    typedef struct packed {
        logic cls;
        logic opc;
        logic rd_query;
        logic fetch;
        logic init;
    } msr_cmd_t;
endpackage
`default_nettype wire

/* msr_rd_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module msr_rd_mem
    import msr_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_we,
    input  wire logic [MEM_AW-1:0] i_waddr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [MEM_AW-1:0] i_raddr,
    output var  logic [DATA_W-1:0] o_rdata
);
    logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];

    // Write-first so a reading landing on the head shows at once
    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        if (i_we && (i_waddr == i_raddr)) begin
            o_rdata <= i_wdata;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule
`default_nettype wire

/* msr_status.sv */
// What this block does
// [RQ1] Message-available flag is high whenever the output buffer holds data.
// [RQ2] Message-available flag sits at status byte bit 4.
// [RQ3] Standard-event summary at status byte bit 5, from enabled event bits.
// [RQ4] Questionable summary at status byte bit 3, from enabled questionable bits.
// [RQ5] Only bits with their enable mask set feed each summary flag.
// [RQ6] Service request only from status byte bits enabled in its mask.
// [RQ7] Operation-complete waits for measurements, then sets event bit 0.
// [RQ8] Event enable value 1 passes only the operation-complete bit.
// [RQ9] Limit failures at questionable bits 11 and 12; mask 6144 unmasks both.
// [RQ10] Limit math flags readings below lower or above upper limit.
// [RQ11] Initiate enters wait-for-trigger; immediate trigger stores readings in memory.
// [RQ12] Exactly the programmed trigger count (zero counts as one) is measured, then the sequence ends.
// [RQ13] Programmed trigger delay precedes every measurement.
// [RQ14] Fetch copies stored readings into the output buffer.
// [RQ15] Read query measures and puts results straight into the output buffer.
// [RQ16] Clear-status clears all latched event flags.
// [RQ17] Averaging math keeps average, minimum and maximum, each readable.
// [RQ18] Host should poll operation-complete, not message-available, for long runs.
// [RQ19] Reading memory holds 512 readings; oldest are dropped beyond that.
// [RQ20] Summary flags follow sources live; serial poll reads current status byte.
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module msr_status
    import msr_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output var  logic [31:0] o_hrdata,
    output var  logic        o_hreadyout,
    output var  logic        o_hresp,
    output var  logic        o_srq,
    output var  logic        o_meas_start,
    input  wire logic        i_meas_valid,
    input  wire logic [31:0] i_meas_data
);
    typedef struct packed {
        msr_seq_t           seq;
        logic [1:0]         math;
        logic [15:0]        tcnt;
        logic [31:0]        tdly;
        logic signed [31:0] limlo;
        logic signed [31:0] limhi;
        logic [15:0]        ques;
        logic [15:0]        qena;
        logic [7:0]         esr;
        logic [7:0]         ese;
        logic [7:0]         sre;
        logic [15:0]        trig_left;
        logic [31:0]        dly_left;
        logic [7:0]         tick_div;
        logic               opc_pend;
        logic               fetch_pend;
        logic               to_obuf;
        logic [8:0]         wr_ptr;
        logic [8:0]         rd_ptr;
        logic [9:0]         mcount;
        logic [9:0]         ocount;
        logic signed [47:0] sum;
        logic [15:0]        nsum;
        logic signed [31:0] vmin;
        logic signed [31:0] vmax;
        logic [31:0]        hrdata;
        logic               meas_start;
        logic               ap_valid;
        logic               ap_write;
        logic [7:0]         ap_addr;
    } msr_state_t;

    localparam msr_state_t ST_RST = '{seq: SEQ_IDLE, tcnt: TCNT_RST, tdly: TDLY_RST, default: '0};

    function automatic msr_cmd_t cmd_decode(input logic [31:0] w);
        msr_cmd_t c;
        c.init     = w[CMD_INIT];
        c.fetch    = w[CMD_FETCH];
        c.rd_query = w[CMD_READ];
        c.opc      = w[CMD_OPC];
        c.cls      = w[CMD_CLS];
        return c;
    endfunction

    function automatic logic [9:0] sat_inc(input logic [9:0] c);
        return (c == MEM_DEPTH) ? c : 10'(c + 10'h001);
    endfunction

    function automatic logic [31:0] avg_of(input logic signed [47:0] sm, input logic [15:0] cnt);
        logic signed [47:0] q;
        q = (cnt == 16'h0000) ? 48'sh0 : sm / $signed({1'b0, cnt});
        return q[31:0];
    endfunction

    msr_state_t         s_reg;
    msr_state_t         s_next;
    msr_cmd_t           cmd;
    logic [7:0]         stb;
    logic               ques_sum;
    logic               esb;
    logic               mav;
    logic               rqs;
    logic               idle;
    logic               start;
    logic               done;
    logic               do_fetch;
    logic               push;
    logic               pop;
    logic               wr_en;
    logic               ap_rd;
    logic signed [31:0] rd;
    logic [31:0]        rdata;
    logic [31:0]        mem_rdata;

    msr_rd_mem u_mem (
        .i_clk_sys (i_clk_sys),
        .i_we      (wr_en),
        .i_waddr   (s_reg.wr_ptr),
        .i_wdata   (i_meas_data),
        .i_raddr   (s_next.rd_ptr),
        .o_rdata   (mem_rdata)
    );

    // Status byte is live, not latched
    always_comb begin
        ques_sum = |(s_reg.ques & s_reg.qena); // RQ4 RQ5 RQ9
        esb      = |(s_reg.esr & s_reg.ese); // RQ3 RQ5 RQ8
        mav      = (s_reg.ocount != 10'h000); // RQ1
        stb      = 8'h00;
        stb[STB_QUES_BIT] = ques_sum; // RQ4
        stb[STB_MAV_BIT]  = mav; // RQ2
        stb[STB_ESB_BIT]  = esb; // RQ3
        rqs = |(stb & s_reg.sre & ~(8'h01 << STB_RQS_BIT)); // RQ6
        stb[STB_RQS_BIT] = rqs; // RQ20
    end

    always_comb begin
        s_next       = s_reg;
        s_next.meas_start = 1'b0;
        cmd          = '0;
        idle         = (s_reg.seq == SEQ_IDLE);
        done         = 1'b0;
        push         = 1'b0;
        wr_en        = 1'b0;
        do_fetch     = 1'b0;
        rd           = $signed(i_meas_data);
        if (s_reg.ap_valid && s_reg.ap_write) begin
            case (s_reg.ap_addr)
                ADDR_CMD:   cmd = cmd_decode(i_hwdata);
                ADDR_CFG:   s_next.math = i_hwdata[1:0];
                ADDR_TCNT:  s_next.tcnt = i_hwdata[15:0];
                ADDR_TDLY:  s_next.tdly = i_hwdata;
                ADDR_LIMLO: s_next.limlo = $signed(i_hwdata);
                ADDR_LIMHI: s_next.limhi = $signed(i_hwdata);
                ADDR_QENA:  s_next.qena = i_hwdata[15:0];
                ADDR_ESE:   s_next.ese = i_hwdata[7:0];
                ADDR_SRE:   s_next.sre = i_hwdata[7:0];
                default: ;
            endcase
        end
        start = idle && (cmd.init || cmd.rd_query);

        // Address phase; read data registered, zero wait states
        ap_rd = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
        s_next.ap_valid = i_hsel && i_hready && i_htrans[1];
        s_next.ap_write = i_hwrite;
        s_next.ap_addr  = i_haddr[7:0];
        case (i_haddr[7:0])
            ADDR_CFG:   rdata = {30'h0, s_reg.math};
            ADDR_TCNT:  rdata = {16'h0, s_reg.tcnt};
            ADDR_TDLY:  rdata = s_reg.tdly;
            ADDR_LIMLO: rdata = s_reg.limlo;
            ADDR_LIMHI: rdata = s_reg.limhi;
            ADDR_QCOND: rdata = {16'h0, s_reg.ques};
            ADDR_QENA:  rdata = {16'h0, s_reg.qena};
            ADDR_ESR:   rdata = {24'h0, s_reg.esr};
            ADDR_ESE:   rdata = {24'h0, s_reg.ese};
            ADDR_SRE:   rdata = {24'h0, s_reg.sre};
            ADDR_STB:   rdata = {24'h0, stb}; // RQ20
            ADDR_OBUF:  rdata = mem_rdata;
            ADDR_OCNT:  rdata = {22'h0, s_reg.ocount};
            ADDR_AVG:   rdata = avg_of(s_reg.sum, s_reg.nsum); // RQ17
            ADDR_MIN:   rdata = s_reg.vmin; // RQ17
            ADDR_MAX:   rdata = s_reg.vmax; // RQ17
            ADDR_SEQ:   rdata = {28'h0, s_reg.seq};
            default:    rdata = 32'h0000_0000;
        endcase
        if (ap_rd) begin
            s_next.hrdata = rdata;
        end
        pop = ap_rd && (i_haddr[7:0] == ADDR_OBUF) && mav;

        // Event registers clear on read; later sets in this cycle still win
        if (ap_rd && (i_haddr[7:0] == ADDR_QCOND)) begin
            s_next.ques = 16'h0000;
        end
        if (ap_rd && (i_haddr[7:0] == ADDR_ESR)) begin
            s_next.esr = 8'h00;
        end
        if (cmd.cls) begin
            s_next.ques     = 16'h0000; // RQ16
            s_next.esr      = 8'h00; // RQ16
            s_next.opc_pend = 1'b0;
        end
        if (cmd.opc) begin
            s_next.opc_pend = 1'b1;
        end
        if (start) begin
            s_next.seq       = SEQ_WTRIG; // RQ11
            s_next.trig_left = (s_reg.tcnt == 16'h0000) ? 16'h0001 : s_reg.tcnt;
            s_next.mcount    = 10'h000;
            s_next.sum       = 48'sh0;
            s_next.nsum      = 16'h0000;
            s_next.vmin      = MIN_INIT;
            s_next.vmax      = MAX_INIT;
            s_next.to_obuf   = cmd.rd_query; // RQ15
            if (cmd.rd_query) begin
                s_next.rd_ptr = s_reg.wr_ptr;
                s_next.ocount = 10'h000;
            end
        end

        unique case (s_reg.seq)
            SEQ_IDLE: ;
            SEQ_WTRIG: begin
                // Immediate source: trigger is taken at once
                s_next.seq      = SEQ_DELAY; // RQ11
                s_next.dly_left = s_reg.tdly;
                s_next.tick_div = 8'h00;
            end
            SEQ_DELAY: begin
                if (s_reg.dly_left == 32'h0000_0000) begin
                    s_next.seq        = SEQ_MEAS; // RQ13
                    s_next.meas_start = 1'b1;
                end else if (s_reg.tick_div == TICK_LAST) begin
                    s_next.tick_div = 8'h00;
                    s_next.dly_left = s_reg.dly_left - 32'h0000_0001; // RQ13
                end else begin
                    s_next.tick_div = s_reg.tick_div + 8'h01;
                end
            end
            SEQ_MEAS: begin
                if (i_meas_valid) begin
                    wr_en         = 1'b1; // RQ11
                    push          = s_reg.to_obuf; // RQ15
                    s_next.wr_ptr = s_reg.wr_ptr + 9'h001; // RQ19
                    s_next.mcount = sat_inc(s_reg.mcount); // RQ19
                    if (s_reg.math == MATH_LIM) begin
                        if (rd < s_reg.limlo) begin
                            s_next.ques[QUES_LO_BIT] = 1'b1; // RQ9 RQ10
                        end
                        if (rd > s_reg.limhi) begin
                            s_next.ques[QUES_HI_BIT] = 1'b1; // RQ9 RQ10
                        end
                    end
                    if (s_reg.math == MATH_AVG) begin
                        s_next.sum  = s_reg.sum + 48'(rd); // RQ17
                        s_next.nsum = s_reg.nsum + 16'h0001;
                        if (rd < s_reg.vmin) begin
                            s_next.vmin = rd;
                        end
                        if (rd > s_reg.vmax) begin
                            s_next.vmax = rd;
                        end
                    end
                    if (s_reg.trig_left <= 16'h0001) begin
                        s_next.seq     = SEQ_IDLE; // RQ12
                        s_next.to_obuf = 1'b0;
                        done           = 1'b1;
                    end else begin
                        s_next.trig_left = s_reg.trig_left - 16'h0001; // RQ12
                        s_next.seq       = SEQ_WTRIG;
                    end
                end
            end
            default: s_next.seq = SEQ_IDLE;
        endcase

        // Output buffer: a window on the reading memory
        if (pop) begin
            s_next.rd_ptr = s_next.rd_ptr + 9'h001;
        end
        if (push && !pop && (s_reg.ocount == MEM_DEPTH)) begin
            s_next.rd_ptr = s_next.rd_ptr + 9'h001; // RQ19
        end else if (push && !pop) begin
            s_next.ocount = s_reg.ocount + 10'h001; // RQ15
        end else if (pop && !push) begin
            s_next.ocount = s_reg.ocount - 10'h001;
        end
        // Fetch while busy is held until the last reading lands
        if (cmd.fetch && idle && !start) begin
            do_fetch = 1'b1;
        end else if (cmd.fetch) begin
            s_next.fetch_pend = 1'b1;
        end
        if (done && s_reg.fetch_pend) begin
            do_fetch = 1'b1;
        end
        if (do_fetch) begin
            s_next.rd_ptr     = s_next.wr_ptr - s_next.mcount[8:0]; // RQ14
            s_next.ocount     = s_next.mcount; // RQ14
            s_next.fetch_pend = 1'b0;
        end
        if (s_reg.opc_pend && idle && !start) begin
            s_next.esr[ESR_OPC_BIT] = 1'b1; // RQ7
            s_next.opc_pend         = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            s_reg <= ST_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_hrdata     = s_reg.hrdata;
    assign o_hreadyout  = 1'b1;
    assign o_hresp      = 1'b0;
    assign o_srq        = rqs; // RQ6
    assign o_meas_start = s_reg.meas_start;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    mav_follow_a: assert property ( // RQ1
        (s_reg.seq == SEQ_MEAS && i_meas_valid && s_reg.to_obuf) |=> stb[4])
        else $error("reading for output buffer did not raise bit 4");
    mav_pos_a: assert property (stb[4] == (s_reg.ocount != 10'h000)) // RQ2
        else $error("bit 4 disagrees with output buffer fill");
    esb_rise_a: assert property ( // RQ3
        ($rose(s_reg.esr[0]) && s_reg.ese == 8'h01) |-> stb[5])
        else $error("enabled event bit 0 did not raise bit 5");
    ques_sum_a: assert property ( // RQ4
        (s_reg.ques[11] && s_reg.qena[11]) |-> stb[3])
        else $error("enabled low limit failure missing from bit 3");
    mask_gate_a: assert property ( // RQ5
        (s_reg.qena == 16'h0000 && s_reg.ese == 8'h00) |-> (!stb[3] && !stb[5]))
        else $error("masked bits reached a summary flag");
    srq_mask_a: assert property ((s_reg.sre == 8'h00) |-> !o_srq) // RQ6
        else $error("service request with empty mask");
    opc_wait_a: assert property ( // RQ7
        $rose(s_reg.esr[0]) |-> ($past(s_reg.seq) == SEQ_IDLE))
        else $error("operation complete set while measuring");
    limit_low_a: assert property ( // RQ10
        (s_reg.seq == SEQ_MEAS && i_meas_valid && s_reg.math == MATH_LIM
         && $signed(i_meas_data) < s_reg.limlo) |=> s_reg.ques[11])
        else $error("low limit failure not flagged");
    trig_end_a: assert property ( // RQ12
        (s_reg.seq == SEQ_MEAS && i_meas_valid && s_reg.trig_left == 16'h0001) |=> idle)
        else $error("sequence did not end after last trigger");
    delay_len_a: assert property ( // RQ13
        (s_reg.seq == SEQ_WTRIG && s_reg.tdly == 32'h0000_0001)
        |-> ##1 (s_reg.seq == SEQ_DELAY) [*8] ##[192:194] (s_reg.seq == SEQ_MEAS))
        else $error("one microsecond delay has wrong length");
    fetch_copy_a: assert property ((idle && cmd.fetch && !start) |=> (s_reg.ocount == s_reg.mcount)) // RQ14
        else $error("fetch did not expose stored readings");
    cls_clear_a: assert property ( // RQ16
        (cmd.cls && idle && !s_reg.opc_pend) |=> (s_reg.ques == 16'h0000 && s_reg.esr == 8'h00))
        else $error("clear status left a flag set");
    mem_cap_a: assert property (s_reg.mcount <= MEM_DEPTH) // RQ19
        else $error("reading count above capacity");

    opc_seen_c: cover property ($rose(s_reg.esr[0]));
    limit_fail_c: cover property ($rose(stb[3]));
    srq_seen_c: cover property ($rose(o_srq));
    obuf_pop_c: cover property (pop);
endmodule
`default_nettype wire

/* msr_frontend_model.sv */
`timescale 1ns/1ps
`default_nettype none
module msr_frontend_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    input  wire logic        i_meas_start,
    input  wire logic [3:0]  i_lag,
    input  wire logic [31:0] i_base,
    output var  logic        o_meas_valid,
    output var  logic [31:0] o_meas_data,
    output var  logic [15:0] o_count
);
    logic       pend;
    logic [3:0] cnt;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pend         <= 1'b0;
            cnt          <= 4'h0;
            o_meas_valid <= 1'b0;
            o_meas_data  <= 32'h0;
            o_count      <= 16'h0;
        end else begin
            o_meas_valid <= 1'b0;
            // Data is only meaningful with valid; scramble it otherwise
            o_meas_data  <= ~o_meas_data;
            if (i_meas_start) begin
                pend <= 1'b1;
                cnt  <= i_lag;
            end else if (pend && cnt == 4'h0) begin
                pend         <= 1'b0;
                o_meas_valid <= 1'b1;
                o_meas_data  <= i_base + 32'(o_count);
                o_count      <= o_count + 16'h1;
            end else if (pend) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* meter_status_reporting_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module meter_status_reporting_tb;
    import msr_pkg::*;
    logic        clk, nrst, hsel, hwrite, hready, hresp, srq, mstart, mvalid;
    logic [1:0]  htrans;
    logic [3:0]  lag;
    logic [15:0] mcnt;
    logic [31:0] haddr, hwdata, hrdata, mdata, base, b0, rd;
    int          n_errors, n_checks, n, d, k, i;
    int          tv[6] = '{5, 1, 9, 2, 8, 9};
    logic [31:0] tq[6] = '{32'h1800, 32'h1800, 32'h1800, 32'h1800, 32'h1800, 32'h0800};
    logic [31:0] tc[6] = '{32'h0, 32'h800, 32'h1000, 32'h0, 32'h0, 32'h1000};
    logic [31:0] ts[6] = '{32'h10, 32'h18, 32'h18, 32'h10, 32'h10, 32'h10};

    msr_status dut (.i_clk_sys(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .o_srq(srq), .o_meas_start(mstart),
        .i_meas_valid(mvalid), .i_meas_data(mdata));
    msr_frontend_model fe (.i_clk_sys(clk), .i_nrst(nrst), .i_meas_start(mstart), .i_lag(lag),
        .i_base(base), .o_meas_valid(mvalid), .o_meas_data(mdata), .o_count(mcnt));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    // Holds each phase until hready is seen high at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int t;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        t = 0;
        do begin @(posedge clk); t++; end while (hready !== 1'b1 && t < 50);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do begin @(posedge clk); t++; end while (hready !== 1'b1 && t < 100);
        rd = hrdata;
        if (t >= 100) begin n_errors++; complete_run(); end
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask

    task automatic rdreg(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Polls one register until every bit of the mask reads high
    task automatic wait_idle(input logic [7:0] a, input logic [31:0] m);
        int t;
        t = 0;
        do begin bus(1'b0, a, 32'h0); t++; end while ((rd & m) !== m && t < 3000);
        if (t >= 3000) begin n_errors++; complete_run(); end
    endtask

    function automatic logic [31:0] avg_of(int b, int cnt);
        int s;
        s = 0;
        for (int j = 0; j < cnt; j++) s += b + j;
        return 32'(s / cnt);
    endfunction

    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    initial begin
        n_errors = 0; n_checks = 0;
        nrst = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
        haddr = 32'h0; hwdata = 32'h0; lag = 4'hF; base = 32'h0;
        rd = $urandom(97560);
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdreg(ADDR_TCNT, 32'h1);
        rdreg(ADDR_TDLY, 32'h0);
        rdreg(ADDR_SEQ, 32'h1);
        rdreg(ADDR_STB, 32'h0);
        rdreg(8'h80, 32'h0);
        // Slow front end keeps the run busy while the completion request waits
        n = $urandom_range(6, 3);
        d = $urandom_range(1, 0);
        base <= 32'($urandom_range(2000, 0)) - 32'd1000;
        wr(ADDR_CFG, {30'h0, MATH_AVG});
        wr(ADDR_TCNT, 32'(n));
        wr(ADDR_TDLY, 32'(d));
        wr(ADDR_ESE, 32'h1);
        wr(ADDR_SRE, 32'h20);
        b0 = base + 32'(mcnt);
        wr(ADDR_CMD, 32'h1 << CMD_INIT);
        k = 0;
        do begin @(posedge clk); #1; k++; end while (mstart !== 1'b1 && k < 2000);
        chk(32'(k >= 200 * d + 1 && k <= 200 * d + 3), 32'h1);
        @(posedge clk);
        wr(ADDR_CMD, 32'h1 << CMD_OPC);
        rdreg(ADDR_STB, 32'h0);
        // Completion seen through the event summary, not message available
        wait_idle(ADDR_STB, 32'h20);
        chk(32'(mcnt) - (b0 - base), 32'(n));
        rdreg(ADDR_STB, 32'h60);
        chk({31'h0, srq}, 32'h1);
        wr(ADDR_SRE, 32'h0);
        #1;
        chk({31'h0, srq}, 32'h0);
        @(posedge clk);
        rdreg(ADDR_ESR, 32'h1);
        rdreg(ADDR_STB, 32'h0);
        rdreg(ADDR_AVG, avg_of(int'(b0), n));
        rdreg(ADDR_MIN, b0);
        rdreg(ADDR_MAX, b0 + 32'(n - 1));
        wr(ADDR_CMD, 32'h1 << CMD_FETCH);
        rdreg(ADDR_OCNT, 32'(n));
        rdreg(ADDR_STB, 32'h10);
        for (i = 0; i < n; i++) rdreg(ADDR_OBUF, b0 + 32'(i));
        rdreg(ADDR_STB, 32'h0);
        wr(ADDR_CMD, 32'h1 << CMD_OPC);
        // Event bit lands one edge after the pending request is seen idle
        @(posedge clk);
        rdreg(ADDR_STB, 32'h20);
        wr(ADDR_CMD, 32'h1 << CMD_CLS);
        rdreg(ADDR_STB, 32'h0);
        // Limit test: in range, below, above, both edges, and one failure masked off
        wr(ADDR_CFG, {30'h0, MATH_LIM});
        wr(ADDR_LIMLO, 32'd2);
        wr(ADDR_LIMHI, 32'd8);
        wr(ADDR_TCNT, 32'h1);
        wr(ADDR_TDLY, 32'h1);
        for (i = 0; i < 6; i++) begin
            lag  <= 4'($urandom_range(15, 0));
            base <= 32'(tv[i]) - 32'(mcnt);
            wr(ADDR_QENA, tq[i]);
            wr(ADDR_CMD, 32'h1 << CMD_READ);
            wait_idle(ADDR_SEQ, 32'h1);
            rdreg(ADDR_STB, ts[i]);
            rdreg(ADDR_OBUF, 32'(tv[i]));
            rdreg(ADDR_QCOND, tc[i]);
            rdreg(ADDR_STB, 32'h0);
        end
        // One reading past the memory depth drops the oldest
        lag <= 4'h0;
        wr(ADDR_CFG, {30'h0, MATH_NONE});
        wr(ADDR_TCNT, 32'd513);
        wr(ADDR_TDLY, 32'h0);
        b0 = base + 32'(mcnt);
        wr(ADDR_CMD, 32'h1 << CMD_INIT);
        wait_idle(ADDR_SEQ, 32'h1);
        wr(ADDR_CMD, 32'h1 << CMD_FETCH);
        rdreg(ADDR_OCNT, 32'd512);
        rdreg(ADDR_OBUF, b0 + 32'h1);
        complete_run();
    end
endmodule
`default_nettype wire
